// ==== shared/aowc_defs.svh ====
`ifndef AOWC_DEFS_SVH
`define AOWC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (serial command address field)
// ----------------------------------------------------------------
`define AOWC_ADDR_IN_CTRL   10'h008
`define AOWC_ADDR_OUT_CTRL  10'h00C
`define AOWC_ADDR_WORD_CTRL 10'h010
`define AOWC_ADDR_PAT_LOW   10'h014
`define AOWC_ADDR_PAT_MID   10'h015
`define AOWC_ADDR_PAT_TOP   10'h016
`define AOWC_ADDR_OFS_CAL   10'h020

// ----------------------------------------------------------------
// writable bits and reset value
// ----------------------------------------------------------------
`define AOWC_MASK_IN_CTRL   8'h03
`define AOWC_MASK_OUT_CTRL  8'hDF
`define AOWC_MASK_WORD_CTRL 8'h0F
`define AOWC_MASK_PAT_BYTE  8'hFF
`define AOWC_MASK_PAT_TOP   8'h0F
`define AOWC_MASK_OFS_CAL   8'h07
`define AOWC_RST_VAL        8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AOWC_CLKSEL_MSB     7
`define AOWC_CLKSEL_LSB     6
`define AOWC_DDR_BIT        4
`define AOWC_LANES_MSB      3
`define AOWC_LANES_LSB      2
`define AOWC_PROTO_MSB      1
`define AOWC_PROTO_LSB      0
`define AOWC_SPAN_MSB       3
`define AOWC_SPAN_LSB       2
`define AOWC_PAR_BIT        1
`define AOWC_PAT_BIT        0
`define AOWC_CPOL_BIT       1
`define AOWC_CPHA_BIT       0

// ----------------------------------------------------------------
// command word: opcode, address, data
// ----------------------------------------------------------------
`define AOWC_WORD_W         22
`define AOWC_OP_MSB         21
`define AOWC_OP_LSB         18
`define AOWC_ADR_MSB        17
`define AOWC_ADR_LSB        8
`define AOWC_DAT_MSB        7
`define AOWC_DAT_LSB        0
`define AOWC_OP_WRITE       4'h1
`define AOWC_OP_READ        4'h2
`define AOWC_PAR_ALL        3
`define AOWC_PAR_SPAN       2

`endif

// ==== shared/aowc_pkg.sv ====
package aowc_pkg;

    typedef enum logic [1:0] {
        AOWC_PROTO_SPI,
        AOWC_PROTO_EARLY,
        AOWC_PROTO_INVALID,
        AOWC_PROTO_SSYNC
    } aowc_proto_type;

    typedef enum logic [1:0] {
        AOWC_CLK_ECHO,
        AOWC_CLK_INT,
        AOWC_CLK_HALF,
        AOWC_CLK_QUARTER
    } aowc_clksel_type;

    typedef struct packed {
        aowc_clksel_type clksel;
        logic            ddr;
        logic [1:0]      lanes;
        aowc_proto_type  proto;
        logic            cpol;
        logic            cpha;
        logic [1:0]      span;
        logic            parity_append;
        logic            pat_sel;
        logic [17:0]     pattern;
    } aowc_cfg_type;

endpackage

// ==== verification/adc_output_word_config_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "aowc_defs.svh"
module adc_output_word_config_bench;
    logic        clk, rst_b, sample_valid, sclk, cs_b, sdi, ready_clk;
    logic [17:0] sample_data;
    logic [3:0]  sdo;
    logic [2:0]  ref_range_code;
    logic [21:0] rsp;
    int          mismatches = 0;
    int          n_checks = 0;

    aowc_core u_dut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .sdi(sdi),
        .sample_data(sample_data), .sample_valid(sample_valid), .sdo(sdo),
        .ready_clk(ready_clk), .ref_range_code(ref_range_code));
    aowc_host u_host (.sdo(sdo), .ready_clk(ready_clk), .sclk(sclk), .cs_b(cs_b),
        .sdi(sdi));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_of_test();
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // commands never carry protocol 10; only t_masks sets do-not-write bits
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        u_host.xfer({`AOWC_OP_WRITE, a, d}, rsp);
    endtask

    task automatic rd_raw(input logic [9:0] a);
        u_host.xfer({`AOWC_OP_READ, a, 8'h00}, rsp);
        u_host.xfer(22'h00_0000, rsp);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
        rd_raw(a);
        chk(rsp, {e, 14'h0000});
    endtask

    function automatic logic [21:0] word(input logic [17:0] d, input logic [1:0] sp);
        logic [17:0] m;
        m = 18'h3_FFFF << (14 - 4 * sp);
        return {d, ^d, ^(d & m), 2'b00};
    endfunction

    task automatic t_reset();
        logic [9:0] a[7];
        a = '{`AOWC_ADDR_IN_CTRL, `AOWC_ADDR_OUT_CTRL, `AOWC_ADDR_WORD_CTRL,
              `AOWC_ADDR_PAT_LOW, `AOWC_ADDR_PAT_MID, `AOWC_ADDR_PAT_TOP, `AOWC_ADDR_OFS_CAL};
        foreach (a[i]) rd_chk(a[i], 8'h00);
    endtask

    task automatic t_masks();
        wr(`AOWC_ADDR_PAT_LOW, 8'hFF);
        wr(`AOWC_ADDR_PAT_MID, 8'hFF);
        wr(`AOWC_ADDR_PAT_TOP, 8'hFF);
        wr(`AOWC_ADDR_OFS_CAL, 8'hFF);
        wr(`AOWC_ADDR_WORD_CTRL, 8'hF0);
        wr(10'h030, 8'hFF);
        rd_chk(`AOWC_ADDR_PAT_LOW, 8'hFF);
        rd_chk(`AOWC_ADDR_PAT_MID, 8'hFF);
        rd_chk(`AOWC_ADDR_PAT_TOP, 8'h0F);
        rd_chk(`AOWC_ADDR_OFS_CAL, 8'h07);
        rd_chk(`AOWC_ADDR_WORD_CTRL, 8'h00);
        rd_chk(10'h030, 8'h00);
        chk({19'h0, ref_range_code}, 22'h00_0000);
        wr(`AOWC_ADDR_OFS_CAL, 8'h05);
        chk({19'h0, ref_range_code}, 22'h00_0005);
    endtask

    task automatic t_pattern();
        logic [17:0] d;
        wr(`AOWC_ADDR_PAT_LOW, 8'h5A);
        wr(`AOWC_ADDR_PAT_MID, 8'hC3);
        wr(`AOWC_ADDR_PAT_TOP, 8'h09);
        @(negedge clk) sample_data = 18'h2_B3C7;
        sample_valid = 1'b1;
        @(negedge clk) sample_valid = 1'b0;
        for (int k = 0; k < 16; k++) begin
            wr(`AOWC_ADDR_WORD_CTRL, 8'(k));
            u_host.xfer(22'h00_0000, rsp);
            d = k[0] ? 18'h1_C35A : 18'h2_B3C7;
            chk(rsp, k[1] ? word(d, 2'(k >> 2)) : {d, 4'h0});
        end
    endtask

    // every input mode, plain then early launch: early shows each bit one edge sooner
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(`AOWC_ADDR_IN_CTRL, 8'(m));
            u_host.mode = 2'(m);
            rd_chk(`AOWC_ADDR_IN_CTRL, 8'(m));
            wr(`AOWC_ADDR_OUT_CTRL, 8'h01);
            rd_raw(`AOWC_ADDR_OUT_CTRL);
            chk(rsp, {8'h01, 14'h0000} << 1);
            wr(`AOWC_ADDR_OUT_CTRL, 8'h00);
        end
        wr(`AOWC_ADDR_IN_CTRL, 8'h00);
        u_host.mode = 2'b00;
    endtask

    // four lanes; data-rate and clock-select set but idle outside protocol 11
    task automatic t_lanes();
        wr(`AOWC_ADDR_OUT_CTRL, 8'h5C);
        rd_raw(`AOWC_ADDR_OUT_CTRL);
        chk(u_host.wide[23:2], {8'h5C, 14'h0000});
        chk(22'(u_host.ss_n), 22'h00_0000);
        wr(`AOWC_ADDR_OUT_CTRL, 8'h4F);
        rd_raw(`AOWC_ADDR_OUT_CTRL);
        chk(u_host.ss_word[23:2], {8'h4F, 14'h0000});
        chk(22'(u_host.ss_n), 22'h00_0006);
        chk({21'h0, ready_clk}, 22'h00_0000);
        wr(`AOWC_ADDR_OUT_CTRL, 8'h00);
    endtask

    initial begin
        rst_b = 1'b0;
        sample_valid = 1'b0;
        sample_data = 18'h0_0000;
        repeat (12) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_masks();
        t_modes();
        t_lanes();
        t_pattern();
        end_of_test();
    end

    initial begin
        #50000;
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== verification/aowc_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module aowc_host (
    input  wire logic [3:0] sdo,
    input  wire logic       ready_clk,
    output logic            sclk,
    output logic            cs_b,
    output logic            sdi
);
    logic [1:0]  mode = 2'b00;
    logic [23:0] wide;
    logic [23:0] ss_word;
    int          ss_n = 0;

    initial begin
        sclk = 1'b0; // mode 00 idles low
        cs_b = 1'b1;
        sdi  = 1'b0;
    end

    // one frame; capture on leading edge for phase 0, trailing for phase 1
    // idle level settles before chip select falls so no stray edge is counted
    task automatic xfer(input logic [21:0] cmd, output logic [21:0] rsp);
        sclk = mode[1];
        ss_n = 0;
        #1 cs_b = 1'b0;
        #7;
        for (int i = 21; i >= 0; i--) begin
            for (int h = 0; h < 2; h++) begin
                if (h == mode[0]) sdi = cmd[i];
                #3 sclk = ~sclk;
                if (h == mode[0]) begin
                    rsp[i] = sdo[0];
                    if (i > 15) wide = {wide[19:0], sdo[0], sdo[1], sdo[2], sdo[3]};
                end
            end
        end
        #3 cs_b = 1'b1; // device acts on this rise
        sdi = ~sdi; // released line has no pull
        #24;
    endtask

    // single-rate source-synchronous data is steady at the falling output clock
    always @(negedge ready_clk) begin
        if (!cs_b && ss_n < 6) begin
            ss_word = {ss_word[19:0], sdo[0], sdo[1], sdo[2], sdo[3]};
            ss_n++;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/aowc_core.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "aowc_defs.svh"

module aowc_core (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        sclk,
    input  wire logic        cs_b,
    input  wire logic        sdi,
    input  wire logic [17:0] sample_data,
    input  wire logic        sample_valid,
    output logic      [3:0]  sdo,
    output logic             ready_clk,
    output logic      [2:0]  ref_range_code
);
    import aowc_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] masked(input logic [7:0] old_v,
                                          input logic [7:0] new_v,
                                          input logic [7:0] m);
        masked = (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic [2:0] lane_num(input logic [1:0] code);
        lane_num = !code[1] ? 3'd1 : (code[0] ? 3'd4 : 3'd2);
    endfunction

    // lane 0 carries the most significant bit of each group
    function automatic logic [3:0] group(input logic [21:0] w,
                                         input logic [1:0]  lw,
                                         input logic [5:0]  idx);
        logic [23:0] s;
        logic [8:0]  amt;
        amt = 9'(idx) * 9'(lane_num(lw));
        s = {w, 2'b00} << amt;
        case (lane_num(lw))
            3'd1:    group = {3'b000, s[23]};
            3'd2:    group = {2'b00, s[22], s[23]};
            default: group = {s[20], s[21], s[22], s[23]};
        endcase
    endfunction

    function automatic logic span_parity(input logic [17:0] d,
                                         input logic [1:0]  span);
        case (span)
            2'b00:   span_parity = ^d[17:14];
            2'b01:   span_parity = ^d[17:10];
            2'b10:   span_parity = ^d[17:6];
            default: span_parity = ^d[17:2];
        endcase
    endfunction

    // ------------------------------------------------------------
    // chip select and serial clock synchronisers
    // ------------------------------------------------------------
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic sclk_s1_reg;
    logic sclk_s2_reg;
    logic frame_end;
    logic frame_start;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
        end else begin
            cs_s1_reg <= cs_b;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
        end else begin
            sclk_s1_reg <= sclk;
            sclk_s2_reg <= sclk_s1_reg;
        end
    end

    assign frame_end   = cs_s2_reg & ~cs_s3_reg;
    assign frame_start = ~cs_s2_reg & cs_s3_reg;

    // ------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------
    logic [7:0] in_ctrl_reg;
    logic [7:0] out_ctrl_reg;
    logic [7:0] word_ctrl_reg;
    logic [7:0] pat_low_reg;
    logic [7:0] pat_mid_reg;
    logic [7:0] pat_top_reg;
    logic [7:0] ofs_cal_reg;
    logic [7:0] rd_data_reg;
    logic       rd_pending_reg;
    aowc_cfg_type cfg;
    logic [23:0]  pat_full;

    assign pat_full = {4'h0, pat_top_reg[3:0], pat_mid_reg, pat_low_reg};

    always_comb begin
        cfg.clksel  = aowc_clksel_type'(out_ctrl_reg[`AOWC_CLKSEL_MSB:`AOWC_CLKSEL_LSB]);
        cfg.ddr     = out_ctrl_reg[`AOWC_DDR_BIT];
        cfg.lanes   = out_ctrl_reg[`AOWC_LANES_MSB:`AOWC_LANES_LSB];
        cfg.proto   = aowc_proto_type'(out_ctrl_reg[`AOWC_PROTO_MSB:`AOWC_PROTO_LSB]);
        cfg.cpol    = in_ctrl_reg[`AOWC_CPOL_BIT];
        cfg.cpha    = in_ctrl_reg[`AOWC_CPHA_BIT];
        cfg.span    = word_ctrl_reg[`AOWC_SPAN_MSB:`AOWC_SPAN_LSB];
        cfg.parity_append  = word_ctrl_reg[`AOWC_PAR_BIT];
        cfg.pat_sel = word_ctrl_reg[`AOWC_PAT_BIT];
        cfg.pattern = pat_full[17:0];
    end

    // ------------------------------------------------------------
    // serial capture, link clock domain
    // ------------------------------------------------------------
    // both edges captured; polarity and phase pick one at frame end
    logic [21:0] shift_pos_reg;
    logic [21:0] shift_neg_reg;

    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            shift_pos_reg <= 22'h00_0000;
        end else if (!cs_b) begin
            shift_pos_reg <= {shift_pos_reg[20:0], sdi};
        end
    end

    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            shift_neg_reg <= 22'h00_0000;
        end else if (!cs_b) begin
            shift_neg_reg <= {shift_neg_reg[20:0], sdi};
        end
    end

    // ------------------------------------------------------------
    // command decode at frame end
    // ------------------------------------------------------------
    // sclk is idle once chip select has risen, so the shift
    // registers are stable when the synchronised edge is seen
    logic [21:0] cmd;
    logic [3:0]  cmd_op;
    logic [9:0]  cmd_adr;
    logic [7:0]  cmd_dat;
    logic        cmd_wr;

    assign cmd     = (cfg.cpol == cfg.cpha) ? shift_pos_reg : shift_neg_reg;
    assign cmd_op  = cmd[`AOWC_OP_MSB:`AOWC_OP_LSB];
    assign cmd_adr = cmd[`AOWC_ADR_MSB:`AOWC_ADR_LSB];
    assign cmd_dat = cmd[`AOWC_DAT_MSB:`AOWC_DAT_LSB];
    assign cmd_wr  = frame_end && (cmd_op == `AOWC_OP_WRITE);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_ctrl_reg   <= `AOWC_RST_VAL;
            out_ctrl_reg  <= `AOWC_RST_VAL;
            word_ctrl_reg <= `AOWC_RST_VAL;
            pat_low_reg   <= `AOWC_RST_VAL;
            pat_mid_reg   <= `AOWC_RST_VAL;
            pat_top_reg   <= `AOWC_RST_VAL;
            ofs_cal_reg   <= `AOWC_RST_VAL;
        end else if (cmd_wr) begin
            // reserved bits never take a write, so they read zero
            if (cmd_adr == `AOWC_ADDR_IN_CTRL) begin
                in_ctrl_reg <= masked(in_ctrl_reg, cmd_dat, `AOWC_MASK_IN_CTRL);
            end else if (cmd_adr == `AOWC_ADDR_OUT_CTRL) begin
                out_ctrl_reg <= masked(out_ctrl_reg, cmd_dat, `AOWC_MASK_OUT_CTRL);
            end else if (cmd_adr == `AOWC_ADDR_WORD_CTRL) begin
                word_ctrl_reg <= masked(word_ctrl_reg, cmd_dat, `AOWC_MASK_WORD_CTRL);
            end else if (cmd_adr == `AOWC_ADDR_PAT_LOW) begin
                pat_low_reg <= masked(pat_low_reg, cmd_dat, `AOWC_MASK_PAT_BYTE);
            end else if (cmd_adr == `AOWC_ADDR_PAT_MID) begin
                pat_mid_reg <= masked(pat_mid_reg, cmd_dat, `AOWC_MASK_PAT_BYTE);
            end else if (cmd_adr == `AOWC_ADDR_PAT_TOP) begin
                pat_top_reg <= masked(pat_top_reg, cmd_dat, `AOWC_MASK_PAT_TOP);
            end else if (cmd_adr == `AOWC_ADDR_OFS_CAL) begin
                ofs_cal_reg <= masked(ofs_cal_reg, cmd_dat, `AOWC_MASK_OFS_CAL);
            end
        end
    end

    // read answer goes out in the following frame
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_pending_reg <= 1'b0;
            rd_data_reg    <= 8'h00;
        end else if (frame_end) begin
            rd_pending_reg <= (cmd_op == `AOWC_OP_READ);
            if (cmd_adr == `AOWC_ADDR_IN_CTRL) begin
                rd_data_reg <= in_ctrl_reg;
            end else if (cmd_adr == `AOWC_ADDR_OUT_CTRL) begin
                rd_data_reg <= out_ctrl_reg;
            end else if (cmd_adr == `AOWC_ADDR_WORD_CTRL) begin
                rd_data_reg <= word_ctrl_reg;
            end else if (cmd_adr == `AOWC_ADDR_PAT_LOW) begin
                rd_data_reg <= pat_low_reg;
            end else if (cmd_adr == `AOWC_ADDR_PAT_MID) begin
                rd_data_reg <= pat_mid_reg;
            end else if (cmd_adr == `AOWC_ADDR_PAT_TOP) begin
                rd_data_reg <= pat_top_reg;
            end else if (cmd_adr == `AOWC_ADDR_OFS_CAL) begin
                rd_data_reg <= ofs_cal_reg;
            end else begin
                rd_data_reg <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // output word
    // ------------------------------------------------------------
    logic [17:0] conv_reg;
    logic [21:0] out_word_reg;
    logic [17:0] payload;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_reg <= 18'h0_0000;
        end else if (sample_valid) begin
            conv_reg <= sample_data;
        end
    end

    assign payload = rd_pending_reg ? {rd_data_reg, 10'h000} :
                     (cfg.pat_sel ? cfg.pattern : conv_reg);

    // frozen while a frame runs so the link side sees a stable word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_word_reg <= 22'h00_0000;
        end else if (cs_s2_reg) begin
            out_word_reg[21:4] <= payload;
            out_word_reg[`AOWC_PAR_ALL]  <= cfg.parity_append & ^payload;
            out_word_reg[`AOWC_PAR_SPAN] <= cfg.parity_append & span_parity(payload, cfg.span);
            out_word_reg[1:0] <= 2'b00;
        end
    end

    // ------------------------------------------------------------
    // plain and early-launch serial output, link clock domain
    // ------------------------------------------------------------
    // value 10 is not expected; it falls back to plain timing
    logic       early;
    logic       launch_pos;
    logic [3:0] pre_reg;
    logic [4:0] pos_cnt_reg;
    logic [4:0] neg_cnt_reg;
    logic [3:0] pos_out_reg;
    logic [3:0] neg_out_reg;

    assign early      = (cfg.proto == AOWC_PROTO_EARLY);
    assign launch_pos = cfg.cpol ^ cfg.cpha;

    // first group must stand before the first launch edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_reg <= 4'h0;
        end else if (cs_s2_reg) begin
            pre_reg <= group(out_word_reg, cfg.lanes, {5'd0, early & ~cfg.cpha});
        end
    end

    // counters cleared by the frame itself; sclk may stop after it
    always_ff @(posedge sclk or posedge cs_b) begin
        if (cs_b) begin
            pos_cnt_reg <= 5'd0;
            pos_out_reg <= 4'h0;
        end else begin
            pos_cnt_reg <= (pos_cnt_reg == 5'd31) ? pos_cnt_reg : pos_cnt_reg + 5'd1;
            pos_out_reg <= group(out_word_reg, cfg.lanes,
                                 6'(pos_cnt_reg) + 6'd1 + 6'(early) - 6'(cfg.cpha));
        end
    end

    always_ff @(negedge sclk or posedge cs_b) begin
        if (cs_b) begin
            neg_cnt_reg <= 5'd0;
            neg_out_reg <= 4'h0;
        end else begin
            neg_cnt_reg <= (neg_cnt_reg == 5'd31) ? neg_cnt_reg : neg_cnt_reg + 5'd1;
            neg_out_reg <= group(out_word_reg, cfg.lanes,
                                 6'(neg_cnt_reg) + 6'd1 + 6'(early) - 6'(cfg.cpha));
        end
    end

    // ------------------------------------------------------------
    // source-synchronous output, internal oscillator is clk
    // ------------------------------------------------------------
    logic       ss_active;
    logic       toggle;
    logic       ss_launch;
    logic       rclk_reg;
    logic [1:0] div_reg;
    logic [4:0] ss_idx_reg;
    logic [3:0] ss_out_reg;

    assign ss_active = ~cs_s2_reg && (cfg.proto == AOWC_PROTO_SSYNC);

    always_comb begin
        case (cfg.clksel)
            AOWC_CLK_ECHO:    toggle = (sclk_s2_reg != rclk_reg);
            AOWC_CLK_INT:     toggle = 1'b1;
            AOWC_CLK_HALF:    toggle = div_reg[0];
            default:          toggle = (div_reg == 2'b11);
        endcase
    end

    // single rate launches on the rising output edge only
    assign ss_launch = ss_active && toggle && (cfg.ddr || !rclk_reg);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rclk_reg <= 1'b0;
            div_reg  <= 2'b00;
        end else if (!ss_active) begin
            rclk_reg <= 1'b0;
            div_reg  <= 2'b00;
        end else begin
            div_reg <= div_reg + 2'b01;
            if (toggle) begin
                rclk_reg <= ~rclk_reg;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ss_idx_reg <= 5'd0;
            ss_out_reg <= 4'h0;
        end else if (!ss_active) begin
            ss_idx_reg <= 5'd0;
            ss_out_reg <= 4'h0;
        end else if (frame_start) begin
            ss_out_reg <= group(out_word_reg, cfg.lanes, 6'd0);
        end else if (ss_launch && ss_idx_reg != 5'd31) begin
            ss_idx_reg <= ss_idx_reg + 5'd1;
            ss_out_reg <= group(out_word_reg, cfg.lanes, 6'(ss_idx_reg) + 6'd1);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // data-rate bit reaches only the source-synchronous path
    always_comb begin
        if (cfg.proto == AOWC_PROTO_SSYNC) begin
            sdo = ss_out_reg;
        end else if (launch_pos) begin
            sdo = (pos_cnt_reg == 5'd0) ? pre_reg : pos_out_reg;
        end else begin
            sdo = (neg_cnt_reg == 5'd0) ? pre_reg : neg_out_reg;
        end
    end

    assign ready_clk = rclk_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_range_code <= 3'b000;
        end else begin
            ref_range_code <= (ofs_cal_reg[2:1] == 2'b11) ? 3'b000 : ofs_cal_reg[2:0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    reserved_zero_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        out_ctrl_reg[5] == 1'b0 && word_ctrl_reg[7:4] == 4'h0 &&
        pat_top_reg[7:4] == 4'h0 && ofs_cal_reg[7:3] == 5'h00)
        else $error("reserved register bit set");

    parity_off_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cs_s2_reg && !cfg.parity_append) |=> out_word_reg[3:2] == 2'b00)
        else $error("parity bits not zero");

    parity_full_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cs_s2_reg && cfg.parity_append) |=> out_word_reg[3] == ^out_word_reg[21:4])
        else $error("full parity wrong");

    pattern_word_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cs_s2_reg && cfg.pat_sel && !rd_pending_reg) |=>
        out_word_reg[21:4] == $past(cfg.pattern))
        else $error("pattern not substituted");

    range_alias_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (ofs_cal_reg[2:1] == 2'b11) |=> ref_range_code == 3'b000)
        else $error("range alias wrong");

    write_apply_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cmd_wr && cmd_adr == `AOWC_ADDR_WORD_CTRL) |=>
        word_ctrl_reg == ($past(cmd_dat) & `AOWC_MASK_WORD_CTRL))
        else $error("write not applied at frame end");

    read_flag_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (frame_end && cmd_op == `AOWC_OP_READ) |=> rd_pending_reg ##1 rd_pending_reg)
        else $error("read answer not pending");

    int_clock_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (ss_active && cfg.clksel == AOWC_CLK_INT) ##1 ss_active |->
        rclk_reg != $past(rclk_reg))
        else $error("internal clock not toggling");

    quarter_hold_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (ss_active && cfg.clksel == AOWC_CLK_QUARTER && div_reg != 2'b11) |=>
        $stable(rclk_reg))
        else $error("quarter clock too fast");

    sdr_launch_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (ss_launch && !cfg.ddr) |-> !rclk_reg ##1 rclk_reg)
        else $error("single rate launch off edge");

    no_ssync_clk_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cfg.proto != AOWC_PROTO_SSYNC) |=> !rclk_reg)
        else $error("output clock outside source sync");

    one_lane_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        !cfg.lanes[1] |-> ss_out_reg[3:1] == 3'b000)
        else $error("extra lanes driven");

endmodule

`default_nettype wire
